// *** verilog/ccb_bridge.v ***
// Clock crossing bridge: master handshake machine and slave handshake machine
`timescale 1ns/1ps
`include "ccb_bridge_map.vh"
module ccb_bridge (
   input wire clk,
   input wire rst,
   input wire ce,
   input wire [`CCB_AW-1:0] m_address,
   input wire m_read,
   input wire m_write,
   input wire [`CCB_DW-1:0] m_writedata,
   input wire [`CCB_BW-1:0] m_byteenable,
   output wire [`CCB_DW-1:0] m_readdata,
   output wire m_waitrequest,
   input wire slave_clk,
   output wire [`CCB_AW-1:0] s_address,
   output wire s_read,
   output wire s_write,
   output wire [`CCB_DW-1:0] s_writedata,
   output wire [`CCB_BW-1:0] s_byteenable,
   input wire [`CCB_DW-1:0] s_readdata,
   input wire s_waitrequest
);

   // ----------------------------------------
   // State codes
   // ----------------------------------------
   localparam M_IDLE = `CCB_M_IDLE;
   localparam M_WAIT = `CCB_M_WAIT;
   localparam M_DONE = `CCB_M_DONE;
   localparam M_DRAIN = `CCB_M_DRAIN;
   localparam S_IDLE = `CCB_S_IDLE;
   localparam S_BUSY = `CCB_S_BUSY;
   localparam S_ACK = `CCB_S_ACK;

   // ----------------------------------------
   // Master side registers
   // ----------------------------------------
   reg [3:0] m_state_q;
   reg [3:0] m_state_d;
   reg req_q;
   reg req_d;
   reg cap_en;
   reg rd_load;
   reg [`CCB_AW-1:0] cap_addr_q;
   reg [`CCB_DW-1:0] cap_wdata_q;
   reg [`CCB_BW-1:0] cap_be_q;
   reg cap_wr_q;
   reg [`CCB_DW-1:0] m_rdata_q;

   // ----------------------------------------
   // Slave side registers
   // ----------------------------------------
   reg [2:0] s_state_q;
   reg [2:0] s_state_d;
   reg ack_q;
   reg ack_d;
   reg s_issue;
   reg s_finish;
   reg s_read_q;
   reg s_write_q;
   reg [`CCB_AW-1:0] s_addr_q;
   reg [`CCB_DW-1:0] s_wdata_q;
   reg [`CCB_BW-1:0] s_be_q;
   reg [`CCB_DW-1:0] s_rdata_q;

   // ----------------------------------------
   // Crossing wires
   // ----------------------------------------
   wire req_s;
   wire ack_m;
   wire sclk_s;
   wire s_edge;
   wire s_wait_s;
   wire [`CCB_DW-1:0] s_rdata_s;
   wire m_req;

   assign m_req = m_read | m_write;

   // ----------------------------------------
   // Synchronizers
   // ----------------------------------------
   // Request into the slave timing domain
   ccb_sync #(
      .W(1),
      .STAGES(`CCB_SYNC_STAGES)
   ) u_req_sync (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .din(req_q),
      .dout(req_s)
   );

   // Acknowledge back into the master timing domain
   ccb_sync #(
      .W(1),
      .STAGES(`CCB_SYNC_STAGES)
   ) u_ack_sync (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .din(ack_q),
      .dout(ack_m)
   );

   // Slave clock is sampled, not used as a clock
   ccb_sync #(
      .W(1),
      .STAGES(`CCB_SYNC_STAGES)
   ) u_sclk_sync (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .din(slave_clk),
      .dout(sclk_s)
   );

   // Slave inputs get one stage more than the clock path, so that the
   // value taken at a found edge is the one that stood just before it
   ccb_sync #(
      .W(1),
      .STAGES(`CCB_DATA_STAGES)
   ) u_swait_sync (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .din(s_waitrequest),
      .dout(s_wait_s)
   );

   ccb_sync #(
      .W(`CCB_DW),
      .STAGES(`CCB_DATA_STAGES)
   ) u_srdata_sync (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .din(s_readdata),
      .dout(s_rdata_s)
   );

   ccb_edge u_sclk_edge (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .level(sclk_s),
      .rise(s_edge)
   );

   // ----------------------------------------
   // Master handshake machine
   // ----------------------------------------
   always @* begin
      m_state_d = m_state_q;
      req_d = req_q;
      cap_en = 1'b0;
      rd_load = 1'b0;
      case (m_state_q)
         M_IDLE: begin
            if (m_req) begin
               cap_en = 1'b1;
               req_d = 1'b1;
               m_state_d = M_WAIT;
            end
         end
         M_WAIT: begin
            if (ack_m) begin
               rd_load = 1'b1;
               req_d = 1'b0;
               m_state_d = M_DONE;
            end
         end
         M_DONE: begin
            m_state_d = M_DRAIN;
         end
         M_DRAIN: begin
            // Next request waits here until the acknowledge falls
            if (!ack_m) begin
               m_state_d = M_IDLE;
            end
         end
         default: begin
            m_state_d = M_IDLE;
            req_d = 1'b0;
         end
      endcase
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         m_state_q <= M_IDLE;
         req_q <= 1'b0;
      end else if (ce) begin
         m_state_q <= m_state_d;
         req_q <= req_d;
      end
   end

   // Request held here, so the master bus is free to change only after
   // release, and the slave side reads a stable copy
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         cap_addr_q <= `CCB_ADDR_RST;
         cap_wdata_q <= `CCB_DATA_RST;
         cap_be_q <= `CCB_BE_RST;
         cap_wr_q <= 1'b0;
      end else if (ce && cap_en) begin
         cap_addr_q <= m_address;
         cap_wdata_q <= m_writedata;
         cap_be_q <= m_byteenable;
         cap_wr_q <= m_write;
      end
   end

   // Read data copy is safe: slave copy is frozen while acknowledge is high
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         m_rdata_q <= `CCB_DATA_RST;
      end else if (ce && rd_load) begin
         m_rdata_q <= s_rdata_q;
      end
   end

   // Stall from the first request cycle; lifted only in the release cycle
   assign m_waitrequest = m_req & (m_state_q != M_DONE);
   assign m_readdata = m_rdata_q;

   // ----------------------------------------
   // Slave handshake machine
   // ----------------------------------------
   // Steps only on found slave clock edges, keeping slave timing
   always @* begin
      s_state_d = s_state_q;
      ack_d = ack_q;
      s_issue = 1'b0;
      s_finish = 1'b0;
      case (s_state_q)
         S_IDLE: begin
            if (s_edge && req_s) begin
               s_issue = 1'b1;
               s_state_d = S_BUSY;
            end
         end
         S_BUSY: begin
            if (s_edge && !s_wait_s) begin
               s_finish = 1'b1;
               ack_d = 1'b1;
               s_state_d = S_ACK;
            end
         end
         S_ACK: begin
            if (s_edge && !req_s) begin
               ack_d = 1'b0;
               s_state_d = S_IDLE;
            end
         end
         default: begin
            s_state_d = S_IDLE;
            ack_d = 1'b0;
         end
      endcase
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         s_state_q <= S_IDLE;
         ack_q <= 1'b0;
      end else if (ce) begin
         s_state_q <= s_state_d;
         ack_q <= ack_d;
      end
   end

   // Slave port strobes: an ordinary single transfer
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         s_read_q <= 1'b0;
         s_write_q <= 1'b0;
      end else if (ce) begin
         if (s_issue) begin
            s_read_q <= ~cap_wr_q;
            s_write_q <= cap_wr_q;
         end else if (s_finish) begin
            s_read_q <= 1'b0;
            s_write_q <= 1'b0;
         end
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         s_addr_q <= `CCB_ADDR_RST;
         s_wdata_q <= `CCB_DATA_RST;
         s_be_q <= `CCB_BE_RST;
      end else if (ce && s_issue) begin
         s_addr_q <= cap_addr_q;
         s_wdata_q <= cap_wdata_q;
         s_be_q <= cap_be_q;
      end
   end

   // Read data kept until the next read transfer finishes
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         s_rdata_q <= `CCB_DATA_RST;
      end else if (ce && s_finish && s_read_q) begin
         s_rdata_q <= s_rdata_s;
      end
   end

   assign s_address = s_addr_q;
   assign s_read = s_read_q;
   assign s_write = s_write_q;
   assign s_writedata = s_wdata_q;
   assign s_byteenable = s_be_q;

   // ----------------------------------------
   // Latency note
   // ----------------------------------------
   // Request path: two sync flops then one slave edge; acknowledge path:
   // two sync flops then one master cycle, inside the overhead budget

endmodule

// *** verilog/ccb_bridge_map.vh ***
// Constants shared by the clock crossing bridge design files
// What this block does
// - Master and slave handshake machines carry read, write and stall.
// - Controls from the other side pass a multi-flop synchronizer first.
// - Needs a slave clock below half the master clock rate, as clk samples it.
// - New request is captured and stall raised in that same master cycle.
// - After capture, master side raises a request that slave side syncs.
// - Slave side runs the read or write on its port, obeying its stall.
// - Slave side acknowledges; master side acts only on the synced copy.
// - Synced acknowledge drops the stall and presents read data.
// - Both ports see ordinary transfers; no extra crossing signals exist.
// - One transfer outstanding; master stalls until the current one ends.
// - Each port's protocol stays in its own clock domain.
// - Overhead at most five master plus five slave cycles per transfer.
`ifndef CCB_BRIDGE_MAP_VH
`define CCB_BRIDGE_MAP_VH

// ----------------------------------------
// Port widths
// ----------------------------------------
`define CCB_AW 32
`define CCB_DW 32
`define CCB_BW 4

// ----------------------------------------
// Synchronizer depths
// ----------------------------------------
`define CCB_SYNC_STAGES 2
`define CCB_DATA_STAGES 3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CCB_ADDR_RST 32'h0000_0000
`define CCB_DATA_RST 32'h0000_0000
`define CCB_BE_RST 4'h0

// ----------------------------------------
// One-hot state codes
// ----------------------------------------
`define CCB_M_IDLE 4'h1
`define CCB_M_WAIT 4'h2
`define CCB_M_DONE 4'h4
`define CCB_M_DRAIN 4'h8
`define CCB_S_IDLE 3'h1
`define CCB_S_BUSY 3'h2
`define CCB_S_ACK 3'h4

`endif

// *** verilog/ccb_sync.v ***
// Multi-stage flip-flop synchronizer for levels from another timing domain
`timescale 1ns/1ps
module ccb_sync #(
   parameter W = 1,
   parameter STAGES = 2
) (
   input wire clk,
   input wire rst,
   input wire ce,
   input wire [W-1:0] din,
   output wire [W-1:0] dout
);

   // ----------------------------------------
   // Flop chain
   // ----------------------------------------
   // Only the next stage reads a stage, so metastability settles in the chain
   reg [W-1:0] chain_q [0:STAGES-1];
   integer i;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         for (i = 0; i < STAGES; i = i + 1) begin
            chain_q[i] <= {W{1'b0}};
         end
      end else if (ce) begin
         chain_q[0] <= din;
         for (i = 1; i < STAGES; i = i + 1) begin
            chain_q[i] <= chain_q[i-1];
         end
      end
   end

   assign dout = chain_q[STAGES-1];

endmodule

// *** verilog/ccb_edge.v ***
// Rising edge finder for an already synchronized slave clock level
`timescale 1ns/1ps
module ccb_edge (
   input wire clk,
   input wire rst,
   input wire ce,
   input wire level,
   output wire rise
);

   // ----------------------------------------
   // Previous sample
   // ----------------------------------------
   reg prev_q;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         prev_q <= 1'b0;
      end else if (ce) begin
         prev_q <= level;
      end
   end

   // One-cycle pulse per slave clock rising edge
   assign rise = level & ~prev_q;

endmodule

// *** tb/ccb_bridge_chk.sv ***
// Checker: port-level properties of the clock crossing bridge
`timescale 1ns/1ps
module ccb_bridge_chk (
   input wire clk,
   input wire rst,
   input wire [31:0] m_address,
   input wire m_read,
   input wire m_write,
   input wire [31:0] m_writedata,
   input wire [3:0] m_byteenable,
   input wire [31:0] m_readdata,
   input wire m_waitrequest,
   input wire [31:0] s_address,
   input wire s_read,
   input wire s_write,
   input wire [31:0] s_writedata,
   input wire [3:0] s_byteenable
);
   wire req = m_read | m_write;
   wire strb = s_read | s_write;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // ----------------------------------------
   // Master port
   // ----------------------------------------
   stall_now_a: assert property (
      $rose(req) |-> m_waitrequest) else $error("no stall on request");
   // Two syncs each way cannot finish sooner
   stall_min_a: assert property (
      $rose(req) |-> m_waitrequest [*8]) else $error("release too early");
   rel_bound_a: assert property (
      $rose(req) |-> ##[1:160] !m_waitrequest) else $error("release late");
   done_once_a: assert property (
      req && !m_waitrequest |=> m_waitrequest || !req)
      else $error("transfer released twice");
   rdata_hold_a: assert property (
      m_read && !m_waitrequest |=> $stable(m_readdata) [*4])
      else $error("read data moved");
   // ----------------------------------------
   // Slave port
   // ----------------------------------------
   one_strobe_a: assert property (
      !(s_read && s_write)) else $error("read and write together");
   strb_stall_a: assert property (
      $rose(strb) |-> m_waitrequest) else $error("slave access unstalled");
   rd_fwd_a: assert property (
      $rose(s_read) |-> m_read && s_address == m_address)
      else $error("bad slave read");
   wr_fwd_a: assert property (
      $rose(s_write) |-> m_write && s_address == m_address &&
      s_writedata == m_writedata && s_byteenable == m_byteenable)
      else $error("bad slave write");
   slv_hold_a: assert property (
      strb && $past(strb) |-> $stable(s_address) &&
      $stable(s_writedata) && $stable(s_byteenable))
      else $error("slave request moved");
endmodule
bind ccb_bridge ccb_bridge_chk chk_u (.clk(clk), .rst(rst),
   .m_address(m_address), .m_read(m_read), .m_write(m_write),
   .m_writedata(m_writedata), .m_byteenable(m_byteenable),
   .m_readdata(m_readdata), .m_waitrequest(m_waitrequest),
   .s_address(s_address), .s_read(s_read), .s_write(s_write),
   .s_writedata(s_writedata), .s_byteenable(s_byteenable));

// *** tb/ccb_slave_model.sv ***
// Slave port model: 16-word memory with programmable stall
`timescale 1ns/1ps
module ccb_slave_model (
   input wire slave_clk,
   input wire rst,
   input wire [3:0] wait_n,
   input wire [31:0] s_address,
   input wire s_read,
   input wire s_write,
   input wire [31:0] s_writedata,
   input wire [3:0] s_byteenable,
   output wire [31:0] s_readdata,
   output wire s_waitrequest
);
   reg [31:0] mem [0:15];
   reg [3:0] cnt_q;
   reg [31:0] last_q;
   integer i;
   wire strb = s_read | s_write;
   wire [3:0] idx = s_address[5:2];
   initial for (i = 0; i < 16; i = i + 1) mem[i] = 32'h0;
   // Stall high when idle: the bridge must not rely on it
   assign s_waitrequest = strb ? (cnt_q < wait_n) : 1'b1;
   // Off-cycle data toggles so stale reads show up
   assign s_readdata = (s_read && !s_waitrequest) ? mem[idx] : ~last_q;
   always @(posedge slave_clk or posedge rst) begin
      if (rst) begin
         cnt_q <= 4'h0;
         last_q <= 32'h0;
      end else begin
         last_q <= s_readdata;
         cnt_q <= (!strb || !s_waitrequest) ? 4'h0 : cnt_q + 4'h1;
         if (s_write && !s_waitrequest) begin
            for (i = 0; i < 4; i = i + 1)
               if (s_byteenable[i]) mem[idx][8*i+:8] <= s_writedata[8*i+:8];
         end
      end
   end
endmodule

// *** tb/tb_top.sv ***
// Testbench: transfers through the bridge to the slave model
`timescale 1ns/1ps
module tb_top;
   reg clk = 0, rst = 1, ce = 1, slave_clk = 0, m_read = 0, m_write = 0;
   reg [31:0] m_address = 0, m_writedata = 0, rd;
   reg [3:0] m_byteenable = 0, wait_n = 0;
   wire [31:0] m_readdata, s_address, s_writedata, s_readdata;
   wire [3:0] s_byteenable;
   wire m_waitrequest, s_read, s_write, s_waitrequest;
   integer n_mismatch = 0, num_checks = 0, cycles = 0, lat, i;
   always #4 clk = ~clk;
   // Slave clock runs free at one eighth of clk, its edges 1 ns after clk rising edges
   initial #5 forever #32 slave_clk = ~slave_clk;
   ccb_bridge dut_u (.clk(clk), .rst(rst), .ce(ce),
      .m_address(m_address), .m_read(m_read), .m_write(m_write),
      .m_writedata(m_writedata), .m_byteenable(m_byteenable),
      .m_readdata(m_readdata), .m_waitrequest(m_waitrequest),
      .slave_clk(slave_clk), .s_address(s_address), .s_read(s_read),
      .s_write(s_write), .s_writedata(s_writedata),
      .s_byteenable(s_byteenable), .s_readdata(s_readdata),
      .s_waitrequest(s_waitrequest));
   ccb_slave_model slv_u (.slave_clk(slave_clk), .rst(rst),
      .wait_n(wait_n), .s_address(s_address), .s_read(s_read),
      .s_write(s_write), .s_writedata(s_writedata),
      .s_byteenable(s_byteenable), .s_readdata(s_readdata),
      .s_waitrequest(s_waitrequest));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task give_verdict;
      begin
         $display("checks %0d mismatches %0d", num_checks, n_mismatch);
         if (n_mismatch == 0 && num_checks > 0) begin
            $display("*** PASS ***");
         end else begin
            $display("*** FAIL ***");
         end
         $finish;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         num_checks = num_checks + 1;
         if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   // Master holds everything until the releasing edge
   task xfer(input w, input [31:0] a, input [31:0] d, input [3:0] be);
      begin
         @(negedge clk);
         m_address = a;
         m_writedata = d;
         m_byteenable = be;
         m_write = w;
         m_read = !w;
         lat = 0;
         do begin
            @(negedge clk);
            lat = lat + 1;
         end while (m_waitrequest !== 1'b0);
         @(negedge clk);
         rd = m_readdata;
         m_read = 0;
         m_write = 0;
      end
   endtask
   // Bound: five each side plus slave access and edge finding
   function [31:0] ok_lat(input integer w);
      ok_lat = {31'h0, lat <= 5 + 8 * (8 + w)};
   endfunction
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_basic;
      begin
         xfer(1, 32'h10, 32'h1234_5678, 4'hF);
         chk(ok_lat(0), 32'h1);
         xfer(1, 32'h14, 32'hCAFE_F00D, 4'h5);
         xfer(0, 32'h10, 32'h0, 4'hF);
         chk(rd, 32'h1234_5678);
         xfer(0, 32'h14, 32'h0, 4'hF);
         chk(rd, 32'h00FE_000D);
         $display("test basic done");
      end
   endtask
   task t_stall;
      begin
         wait_n = 4'h5;
         xfer(1, 32'h20, 32'hA5A5_5A5A, 4'hF);
         xfer(0, 32'h20, 32'h0, 4'hF);
         chk(rd, 32'hA5A5_5A5A);
         chk({31'h0, lat >= 40}, 32'h1);
         chk(ok_lat(5), 32'h1);
         wait_n = 4'h0;
         $display("test stall done");
      end
   endtask
   task t_b2b;
      begin
         for (i = 0; i < 4; i = i + 1)
            xfer(1, 32'h30 + 4 * i, 32'hF0E1_D2C3 ^ i, 4'hF);
         for (i = 0; i < 4; i = i + 1) begin
            xfer(0, 32'h30 + 4 * i, 32'h0, 4'hF);
            chk(rd, 32'hF0E1_D2C3 ^ i);
         end
         $display("test back to back done");
      end
   endtask
   task t_ce;
      begin
         @(negedge clk);
         ce = 0;
         m_address = 32'h10;
         m_read = 1;
         // Frozen bridge must neither take nor finish the request
         repeat (24) begin
            @(negedge clk);
            chk({30'h0, m_waitrequest, s_read}, 32'h2);
         end
         m_read = 0;
         ce = 1;
         xfer(0, 32'h10, 32'h0, 4'hF);
         chk(rd, 32'h1234_5678);
         $display("test enable done");
      end
   endtask
   task t_rst;
      begin
         @(negedge clk);
         m_address = 32'h10;
         m_read = 1;
         repeat (12) @(negedge clk);
         rst = 1;
         @(negedge clk);
         chk({31'h0, m_waitrequest}, 32'h1);
         chk({31'h0, s_read}, 32'h0);
         m_read = 0;
         repeat (2) @(negedge clk);
         rst = 0;
         xfer(0, 32'h10, 32'h0, 4'hF);
         chk(rd, 32'h1234_5678);
         $display("test reset done");
      end
   endtask
   // ----------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         n_mismatch = n_mismatch + 1;
         give_verdict;
      end
   end
   initial begin
      repeat (16) @(posedge clk);
      @(negedge clk);
      rst = 0;
      t_basic;
      t_stall;
      t_b2b;
      t_ce;
      t_rst;
      give_verdict;
   end
endmodule
